// ==== hdl/fuse_cfg_pkg.sv ====
// Purpose: constants for the configuration loader and lock gate
// Assumes: byte-wide configuration store, 10 MHz clock
// Notes: offsets are configuration byte addresses
`default_nettype none
package fuse_cfg_pkg;
    localparam logic [7:0] off_system_config_zero = 8'h05;
    localparam logic [7:0] off_system_config_one = 8'h06;
    localparam logic [7:0] off_app_code_end_cfg = 8'h07;
    localparam logic [7:0] off_boot_end_cfg = 8'h08;
    localparam logic [7:0] off_lock_key_cfg = 8'h0A;

    localparam logic [7:0] rst_system_config_zero = 8'hC0;
    localparam logic [7:0] rst_system_config_one = 8'h07;
    localparam logic [7:0] rst_app_code_end_cfg = 8'h00;
    localparam logic [7:0] rst_boot_end_cfg = 8'h00;
    localparam logic [7:0] rst_lock_key_cfg = 8'hC5;

    localparam int crc_src_msb = 7;
    localparam int crc_src_lsb = 6;
    localparam int reset_pin_bit = 3;
    localparam int eeprom_keep_bit = 0;
    localparam int startup_msb = 2;
    localparam int startup_lsb = 0;

    localparam logic [7:0] open_key = 8'hC5;
    localparam int block_shift = 8;

    typedef enum logic [1:0] {
        crc_full_flash = 2'h0,
        crc_boot_only = 2'h1,
        boot_and_app_crc = 2'h2,
        no_crc_scan = 2'h3
    } crc_source_e;

    typedef enum logic [2:0] {
        mem_sram = 3'h0,
        mem_registers = 3'h1,
        mem_flash = 3'h2,
        mem_eeprom = 3'h3,
        mem_user_data_row = 3'h4,
        mem_signature_row = 3'h5,
        mem_fuses = 3'h6,
        mem_debug_cs = 3'h7
    } mem_space_e;

    localparam int clock_hz = 10_000_000;
    localparam int ms_per_unit = 1;
    localparam int cycles_per_ms = clock_hz / 1000 * ms_per_unit;
    localparam int startup_max_ms = 64;
endpackage
`default_nettype wire

// ==== hdl/startup_delay_timer.sv ====
// Purpose: holds code execution off for the selected start-up time
// Assumes: a 1 ms tick enable from the parent
// Notes: code 0 releases at once
`timescale 1ns/10ps
`default_nettype none
module startup_delay_timer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [2:0] select,
    input wire logic ms_tick,
    output logic done
);
    logic [6:0] target_r;
    logic [6:0] count_r;
    logic run_r;

    function automatic logic [6:0] delay_ms(input logic [2:0] code);
        delay_ms = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
    endfunction

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_r <= 1'b0;
            count_r <= 7'h00;
            target_r <= 7'h00;
            done <= 1'b0;
        end else if (start) begin
            run_r <= 1'b1;
            count_r <= 7'h00;
            target_r <= delay_ms(select);
            done <= 1'b0;
        end else if (run_r) begin
            if (count_r >= target_r) begin
                run_r <= 1'b0;
                done <= 1'b1;
            end else if (ms_tick) begin
                count_r <= 7'(count_r + 7'h01);
            end
        end
    end
endmodule // startup_delay_timer
`default_nettype wire

// ==== hdl/ms_tick_divider.sv ====
// Purpose: one-cycle enable every millisecond
// Assumes: single clock
// Notes: count set by parameter
`timescale 1ns/10ps
`default_nettype none
module ms_tick_divider #(
    parameter int cycles = fuse_cfg_pkg::cycles_per_ms
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic tick
);
    logic [31:0] count_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (count_r >= 32'(cycles - 1)) begin
            count_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            count_r <= 32'(count_r + 32'h0000_0001);
            tick <= 1'b0;
        end
    end
endmodule // ms_tick_divider
`default_nettype wire

// ==== hdl/fuse_config_and_lock_gate.sv ====
// Purpose: loads configuration bytes after reset, decodes options, gates debug access
// Assumes: configuration store read port answers in the cycle after the address
// Notes: values held until the next reset
`timescale 1ns/10ps
`default_nettype none
module fuse_config_and_lock_gate #(
    parameter int flash_bytes = 49152,
    parameter int ms_cycles = fuse_cfg_pkg::cycles_per_ms
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic [7:0] cfg_addr,
    output logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    output logic cfg_loaded,
    output logic code_run,
    output logic [1:0] crc_source_select,
    output logic crc_scan_enable,
    output logic [23:0] crc_scan_end,
    output logic reset_pin_function,
    output logic eeprom_keep_on_erase,
    output logic device_locked,
    output logic [23:0] boot_section_end,
    output logic [23:0] app_code_end,
    input wire logic chip_erase_req,
    output logic eeprom_erase,
    input wire logic [2:0] dbg_space,
    input wire logic dbg_rd,
    input wire logic dbg_wr,
    output logic dbg_rd_grant,
    output logic dbg_wr_grant,
    input wire logic [2:0] cpu_space,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    output logic cpu_rd_grant,
    output logic cpu_wr_grant
);
    typedef enum logic [2:0] {
        ld_zero = 3'h0,
        ld_one = 3'h1,
        ld_app = 3'h2,
        ld_boot = 3'h3,
        ld_lock = 3'h4,
        ld_done = 3'h5
    } load_state_e;

    localparam int slots = 5;

    load_state_e state_r;
    load_state_e state_nxt;
    logic [7:0] hold_r [0:slots-1];
    logic [7:0] sys0_r;
    logic [7:0] sys1_r;
    logic [7:0] app_r;
    logic [7:0] boot_r;
    logic [7:0] lock_r;
    logic pend_r;
    logic ms_tick;
    logic start_pulse;
    logic [23:0] flash_top;
    logic [23:0] boot_bytes;
    logic [23:0] app_bytes;
    logic [7:0] dbg_rd_ok;
    logic [7:0] dbg_wr_ok;
    logic [7:0] cpu_wr_ok;

    assign flash_top = 24'(flash_bytes);

    // value a holding slot takes while reset is applied
    function automatic logic [7:0] hold_default(input int slot);
        case (slot)
            0: hold_default = fuse_cfg_pkg::rst_system_config_zero;
            1: hold_default = fuse_cfg_pkg::rst_system_config_one;
            2: hold_default = fuse_cfg_pkg::rst_app_code_end_cfg;
            3: hold_default = fuse_cfg_pkg::rst_boot_end_cfg;
            default: hold_default = fuse_cfg_pkg::rst_lock_key_cfg;
        endcase
    endfunction

    // block count to byte address
    function automatic logic [23:0] blocks_to_bytes(input logic [7:0] blocks);
        blocks_to_bytes = 24'(blocks) << fuse_cfg_pkg::block_shift;
    endfunction

    function automatic logic is_own_space(input logic [2:0] space);
        is_own_space = (space == fuse_cfg_pkg::mem_debug_cs);
    endfunction

    function automatic logic is_read_only(input logic [2:0] space);
        is_read_only = (space == fuse_cfg_pkg::mem_signature_row);
    endfunction

    function automatic logic is_fuse_space(input logic [2:0] space);
        is_fuse_space = (space == fuse_cfg_pkg::mem_fuses);
    endfunction

    function automatic logic [7:0] load_addr(input load_state_e s);
        unique case (s)
            ld_zero: load_addr = fuse_cfg_pkg::off_system_config_zero;
            ld_one: load_addr = fuse_cfg_pkg::off_system_config_one;
            ld_app: load_addr = fuse_cfg_pkg::off_app_code_end_cfg;
            ld_boot: load_addr = fuse_cfg_pkg::off_boot_end_cfg;
            ld_lock: load_addr = fuse_cfg_pkg::off_lock_key_cfg;
            default: load_addr = 8'h00;
        endcase
    endfunction

    // next step of the load sequence, one byte per two cycles
    always_comb begin
        state_nxt = state_r;
        if (pend_r) begin
            unique case (state_r)
                ld_zero: state_nxt = ld_one;
                ld_one: state_nxt = ld_app;
                ld_app: state_nxt = ld_boot;
                ld_boot: state_nxt = ld_lock;
                ld_lock: state_nxt = ld_done;
                default: state_nxt = ld_done;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= ld_zero;
        end else begin
            state_r <= state_nxt;
        end
    end

    // strobe cycle, then capture cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_r <= 1'b0;
        end else if (state_r != ld_done) begin
            pend_r <= ~pend_r;
        end
    end

    // holding registers written only during load; slot index follows load step
    always_ff @(posedge clock) begin
        for (int i = 0; i < slots; i++) begin
            if (sys_rst) begin
                hold_r[i] <= hold_default(i);
            end else if (pend_r && (state_r == load_state_e'(3'(i)))) begin
                hold_r[i] <= cfg_rdata;
            end
        end
    end

    assign sys0_r = hold_r[0];
    assign sys1_r = hold_r[1];
    assign app_r = hold_r[2];
    assign boot_r = hold_r[3];
    assign lock_r = hold_r[4];

    assign cfg_addr = load_addr(state_r);
    assign cfg_rd = (state_r != ld_done) && !pend_r;
    assign cfg_loaded = (state_r == ld_done);
    assign start_pulse = pend_r && (state_r == ld_lock);

    ms_tick_divider #(.cycles(ms_cycles)) u_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(ms_tick)
    );

    startup_delay_timer u_sut (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(start_pulse),
        .select(sys1_r[fuse_cfg_pkg::startup_msb:fuse_cfg_pkg::startup_lsb]),
        .ms_tick(ms_tick),
        .done(code_run)
    );

    assign device_locked = cfg_loaded ? (lock_r != fuse_cfg_pkg::open_key) : 1'b1;
    assign reset_pin_function = sys0_r[fuse_cfg_pkg::reset_pin_bit];
    assign eeprom_keep_on_erase = sys0_r[fuse_cfg_pkg::eeprom_keep_bit];
    assign crc_source_select = sys0_r[fuse_cfg_pkg::crc_src_msb:fuse_cfg_pkg::crc_src_lsb];

    assign boot_bytes = blocks_to_bytes(boot_r);
    assign app_bytes = blocks_to_bytes(app_r);

    // section boundaries in 256-byte blocks
    always_comb begin
        boot_section_end = boot_bytes;
        app_code_end = app_bytes;
        if (boot_r == 8'h00) begin
            boot_section_end = flash_top;
            app_code_end = flash_top;
        end else if (app_r == 8'h00) begin
            app_code_end = flash_top;
        end
    end

    always_comb begin
        crc_scan_enable = 1'b1;
        unique case (crc_source_select)
            2'h0: crc_scan_end = flash_top;
            2'h1: crc_scan_end = boot_section_end;
            2'h2: crc_scan_end = app_code_end;
            2'h3: begin
                crc_scan_end = 24'h000000;
                crc_scan_enable = 1'b0;
            end
        endcase
    end

    // locked erase ignores keep bit
    always_comb begin
        if (device_locked) begin
            eeprom_erase = chip_erase_req;
        end else begin
            eeprom_erase = chip_erase_req && !eeprom_keep_on_erase;
        end
    end

    // access table per memory space
    generate
        for (genvar g = 0; g < 8; g++) begin : g_space
            localparam logic [2:0] sp = 3'(g);
            assign dbg_rd_ok[g] = is_own_space(sp) || !device_locked;
            assign dbg_wr_ok[g] = is_own_space(sp) || (!device_locked && !is_read_only(sp));
            assign cpu_wr_ok[g] = !is_read_only(sp) && !is_fuse_space(sp);
        end
    endgenerate

    // debug port gating
    always_comb begin
        dbg_rd_grant = dbg_rd && dbg_rd_ok[dbg_space];
        dbg_wr_grant = dbg_wr && dbg_wr_ok[dbg_space];
    end

    // cpu is not affected by lock
    always_comb begin
        cpu_rd_grant = cpu_rd;
        cpu_wr_grant = cpu_wr && cpu_wr_ok[cpu_space];
    end
endmodule // fuse_config_and_lock_gate
`default_nettype wire

// ==== dv/fuse_gate_chk.sv ====
// Purpose: port assertions for the loader and lock gate
// Assumes: single clock, synchronous active high reset
// Notes: bound into the top module
`timescale 1ns/10ps
`default_nettype none
module fuse_gate_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cfg_loaded,
    input wire logic code_run,
    input wire logic [1:0] crc_source_select,
    input wire logic crc_scan_enable,
    input wire logic [23:0] crc_scan_end,
    input wire logic eeprom_keep_on_erase,
    input wire logic device_locked,
    input wire logic [23:0] boot_section_end,
    input wire logic chip_erase_req,
    input wire logic eeprom_erase,
    input wire logic [2:0] dbg_space,
    input wire logic dbg_rd,
    input wire logic dbg_wr,
    input wire logic dbg_rd_grant,
    input wire logic dbg_wr_grant,
    input wire logic cpu_rd,
    input wire logic cpu_rd_grant
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    property p_scan;
        crc_scan_enable == (crc_source_select != 2'h3);
    endproperty
    a_scan: assert property (p_scan) else $error("scan enable wrong");
    property p_noscan;
        crc_source_select == 2'h3 |-> crc_scan_end == 24'h000000;
    endproperty
    a_noscan: assert property (p_noscan) else $error("scan end not zero");
    property p_erase;
        eeprom_erase == (chip_erase_req && (device_locked || !eeprom_keep_on_erase));
    endproperty
    a_erase: assert property (p_erase) else $error("eeprom erase wrong");
    property p_cpu;
        cpu_rd |-> cpu_rd_grant;
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu read refused");
    property p_sig;
        dbg_wr && dbg_space == 3'h5 |-> !dbg_wr_grant;
    endproperty
    a_sig: assert property (p_sig) else $error("signature write granted");
    property p_lock;
        device_locked && dbg_rd && dbg_space != 3'h7 |-> !dbg_rd_grant;
    endproperty
    a_lock: assert property (p_lock) else $error("locked read granted");
    property p_own;
        dbg_rd && dbg_space == 3'h7 |-> dbg_rd_grant;
    endproperty
    a_own: assert property (p_own) else $error("own space refused");
    property p_hold;
        cfg_loaded && $past(cfg_loaded) |-> $stable(device_locked) && $stable(boot_section_end);
    endproperty
    a_hold: assert property (p_hold) else $error("decoded value moved");
    property p_load;
        $fell(sys_rst) |-> !cfg_loaded ##[8:12] cfg_loaded;
    endproperty
    a_load: assert property (p_load) else $error("load not done");
    property p_run;
        code_run |=> code_run;
    endproperty
    a_run: assert property (p_run) else $error("code run dropped");
    property p_wait;
        !cfg_loaded |-> !code_run;
    endproperty
    a_wait: assert property (p_wait) else $error("code run early");
endmodule // fuse_gate_chk
bind fuse_config_and_lock_gate fuse_gate_chk u_chk (.clock, .sys_rst, .cfg_loaded, .code_run,
    .crc_source_select, .crc_scan_enable, .crc_scan_end, .eeprom_keep_on_erase, .device_locked,
    .boot_section_end, .chip_erase_req, .eeprom_erase, .dbg_space, .dbg_rd, .dbg_wr,
    .dbg_rd_grant, .dbg_wr_grant, .cpu_rd, .cpu_rd_grant);
`default_nettype wire

// ==== dv/cfg_store_model.sv ====
// Purpose: configuration byte store with a programming port
// Assumes: byte answers in the cycle after the read strobe
// Notes: output toggles when not read
`timescale 1ns/10ps
`default_nettype none
module cfg_store_model (
    input wire logic clock,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    input wire logic prog_we,
    input wire logic [7:0] prog_addr,
    input wire logic [7:0] prog_data
);
    logic [7:0] mem_r [0:15] = '{5: 8'hC0, 6: 8'h07, 10: 8'hC5, default: 8'h00};
    initial cfg_rdata = 8'h00;
    always @(posedge clock) begin
        if (prog_we) begin
            mem_r[prog_addr[3:0]] <= prog_data;
        end
        if (cfg_rd) begin
            cfg_rdata <= mem_r[cfg_addr[3:0]];
        end else begin
            cfg_rdata <= ~cfg_rdata;
        end
    end
endmodule // cfg_store_model
`default_nettype wire

// ==== dv/tb_fuse_config_and_lock_gate.sv ====
// Purpose: directed tests of load, decode and access gating
// Assumes: ms_cycles shortened to 10
// Notes: access inputs held high, space swept
`timescale 1ns/10ps
`default_nettype none
module tb_fuse_config_and_lock_gate;
    logic clock, sys_rst = 1'b1, chip_erase_req = 1'b0, prog_we = 1'b0;
    logic dbg_rd = 1'b1, dbg_wr = 1'b1, cpu_rd = 1'b1, cpu_wr = 1'b1;
    logic [2:0] dbg_space = 3'h0, cpu_space = 3'h0;
    logic [7:0] prog_addr = 8'h00, prog_data = 8'h00, cfg_addr, cfg_rdata;
    logic cfg_rd, cfg_loaded, code_run, crc_scan_enable, reset_pin_function;
    logic eeprom_keep_on_erase, device_locked, eeprom_erase;
    logic dbg_rd_grant, dbg_wr_grant, cpu_rd_grant, cpu_wr_grant;
    logic [1:0] crc_source_select;
    logic [23:0] crc_scan_end, boot_section_end, app_code_end;
    int bad_count = 0, tests_run = 0, n;
    fuse_config_and_lock_gate #(.ms_cycles(10)) DUT (.clock, .sys_rst, .cfg_addr, .cfg_rd,
        .cfg_rdata, .cfg_loaded, .code_run, .crc_source_select, .crc_scan_enable, .crc_scan_end,
        .reset_pin_function, .eeprom_keep_on_erase, .device_locked, .boot_section_end,
        .app_code_end, .chip_erase_req, .eeprom_erase, .dbg_space, .dbg_rd, .dbg_wr,
        .dbg_rd_grant, .dbg_wr_grant, .cpu_space, .cpu_rd, .cpu_wr, .cpu_rd_grant, .cpu_wr_grant);
    cfg_store_model u_store (.clock, .cfg_addr, .cfg_rd, .cfg_rdata, .prog_we, .prog_addr,
        .prog_data);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        prog_we <= 1'b1;
        prog_addr <= a;
        prog_data <= d;
        @(posedge clock);
        prog_we <= 1'b0;
    endtask
    task automatic reboot();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        n = 0;
        while (cfg_loaded !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        chk("cfg_loaded", cfg_loaded, 1);
        chk("load_cycles", 24'(n), 11);
        n = 0;
    endtask
    task automatic wait_run();
        while (code_run !== 1'b1 && n < 1000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic sweep(input logic lk);
        for (int s = 0; s < 8; s++) begin
            @(posedge clock);
            dbg_space <= 3'(s);
            cpu_space <= 3'(s);
            @(negedge clock);
            chk("dbg_rd_grant", dbg_rd_grant, !lk || s == 7);
            chk("dbg_wr_grant", dbg_wr_grant, (!lk && s != 5) || s == 7);
            chk("cpu_rd_grant", cpu_rd_grant, 1);
            if (s < 7) chk("cpu_wr_grant", cpu_wr_grant, s < 5);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
    initial begin
        reboot();
        chip_erase_req <= 1'b1;
        chk("crc_source_select", crc_source_select, 3);
        chk("crc_scan_enable", crc_scan_enable, 0);
        chk("reset_pin_function", reset_pin_function, 0);
        chk("device_locked", device_locked, 0);
        chk("boot_section_end", boot_section_end, 24'h00C000);
        chk("app_code_end", app_code_end, 24'h00C000);
        wait_run();
        chk("start_wait_64", n >= 630 && n <= 655, 1);
        chk("eeprom_erase", eeprom_erase, 1);
        $display("test defaults done");
        prog(8'h05, 8'h49);
        prog(8'h06, 8'h00);
        prog(8'h07, 8'h40);
        prog(8'h08, 8'h10);
        chk("old_crc", crc_source_select, 3);
        reboot();
        wait_run();
        chk("start_wait_0", n <= 3, 1);
        chk("crc_scan_end", crc_scan_end, 24'h001000);
        chk("boot_section_end", boot_section_end, 24'h001000);
        chk("app_code_end", app_code_end, 24'h004000);
        chk("reset_pin_function", reset_pin_function, 1);
        chk("eeprom_keep_on_erase", eeprom_keep_on_erase, 1);
        chk("eeprom_erase", eeprom_erase, 0);
        sweep(1'b0);
        $display("test open device done");
        for (int c = 0; c < 3; c += 2) begin
            prog(8'h05, {2'(c), 6'h09});
            reboot();
            chk("crc_scan_end", crc_scan_end, c == 0 ? 24'h00C000 : 24'h004000);
        end
        $display("test crc ranges done");
        prog(8'h0A, 8'h3A);
        prog(8'h07, 8'h00);
        reboot();
        chk("device_locked", device_locked, 1);
        chk("eeprom_erase", eeprom_erase, 1);
        chk("app_code_end", app_code_end, 24'h00C000);
        sweep(1'b1);
        $display("test locked device done");
        print_verdict();
    end
endmodule // tb_fuse_config_and_lock_gate
`default_nettype wire
